// file: hw/reloc_pkg.sv
package reloc_pkg;

  // Control register index and byte address on the register bus.
  localparam int unsigned CTRL_INDEX = 'h35;
  localparam logic [31:0] CTRL_ADDR = 32'(CTRL_INDEX * 4);
  // Read-only status register index and byte address.
  localparam int unsigned STAT_INDEX = 'h36;
  localparam logic [31:0] STAT_ADDR = 32'(STAT_INDEX * 4);

  // Control register fields.
  localparam int unsigned UNLOCK_BIT = 0;
  localparam int unsigned SELECT_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register fields.
  localparam int unsigned ST_MASK_BIT = 0;
  localparam int unsigned ST_LOCK_BIT = 1;
  localparam int unsigned ST_RSTFUSE_BIT = 2;
  localparam int unsigned ST_SIZE_LSB = 3;

  // Sequence timing, in clock cycles.
  localparam logic [2:0] UNLOCK_WINDOW_CYCLES = 3'h4;
  localparam logic [2:0] POST_WRITE_MASK_CYCLES = 3'h2;

  // Program flash geometry, in words.
  localparam int unsigned ADDR_W = 17;
  localparam logic [17:0] FLASH_WORDS = 18'h2_0000;
  localparam logic [16:0] APP_RESET_ADDR = 17'h0_0000;
  localparam logic [16:0] VECTOR_SLOT_WORDS = 17'h0_0002;
  localparam logic [17:0] BOOT_WORDS_SIZE0 = 18'h0_1000;
  localparam logic [17:0] BOOT_WORDS_SIZE1 = 18'h0_0800;
  localparam logic [17:0] BOOT_WORDS_SIZE2 = 18'h0_0400;
  localparam logic [17:0] BOOT_WORDS_SIZE3 = 18'h0_0200;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Relocation sequence states, one bit apart from IDLE to OPEN to TAIL; TAIL back to IDLE flips both bits.
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_OPEN = 2'b01,
    SEQ_TAIL = 2'b11
  } seq_state_e;

endpackage

// file: hw/reloc_ctrl_if.sv
`timescale 1ns/10ps
`default_nettype none

interface reloc_ctrl_if;
  logic wr_stb;
  logic wr_unlock;
  logic wr_select;
  logic select;
  logic unlock;
  logic mask;

  modport seq (
    input wr_stb,
    input wr_unlock,
    input wr_select,
    output select,
    output unlock,
    output mask
  );

  modport host (
    output wr_stb,
    output wr_unlock,
    output wr_select,
    input select,
    input unlock,
    input mask
  );
endinterface

`default_nettype wire

// file: hw/vector_unlock_seq.sv
`timescale 1ns/10ps
`default_nettype none

module vector_unlock_seq (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  reloc_ctrl_if.seq ctl
);

  reloc_pkg::seq_state_e state_r;
  reloc_pkg::seq_state_e state_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic select_r;
  logic select_nxt;

  always_comb begin
    state_nxt = state_r;
    select_nxt = select_r;
    cnt_nxt = (cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0;
    if (ctl.wr_stb && ctl.wr_unlock) begin
      // Writing the unlock bit opens or restarts the window.
      state_nxt = reloc_pkg::SEQ_OPEN;
      cnt_nxt = reloc_pkg::UNLOCK_WINDOW_CYCLES;
    end else if (ctl.wr_stb && state_r == reloc_pkg::SEQ_OPEN) begin
      // Select write inside the window: take it, drop unlock at once.
      select_nxt = ctl.wr_select;
      state_nxt = reloc_pkg::SEQ_TAIL;
      cnt_nxt = reloc_pkg::POST_WRITE_MASK_CYCLES;
    end else begin
      // A select write with no open window changes nothing.
      case (state_r)
        reloc_pkg::SEQ_OPEN: begin
          if (cnt_r == 3'h1) begin
            state_nxt = reloc_pkg::SEQ_IDLE;
          end
        end
        reloc_pkg::SEQ_TAIL: begin
          if (cnt_r == 3'h1) begin
            state_nxt = reloc_pkg::SEQ_IDLE;
          end
        end
        default: begin
          state_nxt = reloc_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= reloc_pkg::SEQ_IDLE;
      cnt_r <= 3'h0;
      select_r <= reloc_pkg::CTRL_RESET[reloc_pkg::SELECT_BIT];
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      select_r <= select_nxt;
    end
  end

  assign ctl.select = select_r;
  assign ctl.unlock = (state_r == reloc_pkg::SEQ_OPEN);
  // Dispatch is masked from the very cycle unlock reads as set.
  assign ctl.mask = (state_r != reloc_pkg::SEQ_IDLE);

endmodule

`default_nettype wire

// file: hw/vector_table_relocation.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module vector_table_relocation (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic [1:0] boot_size_fuses_i,
  input wire logic boot_reset_fuse_i,
  input wire logic application_lock_bit_i,
  input wire logic boot_section_lock_bit_i,
  input wire logic exec_in_boot_i,
  input wire logic global_int_enable_i,
  input wire logic [4:0] vector_num_i,
  output logic [16:0] vector_addr_o,
  output logic [16:0] vector_base_o,
  output logic [16:0] reset_addr_o,
  output logic dispatch_mask_o,
  output logic dispatch_enable_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Address arithmetic.

  // Boot section start in words: flash top minus the boot section size.
  function automatic logic [16:0] boot_start(input logic [1:0] size_sel);
    logic [17:0] words;
    words = reloc_pkg::BOOT_WORDS_SIZE3;
    if (size_sel == 2'h0) begin
      words = reloc_pkg::BOOT_WORDS_SIZE0;
    end else if (size_sel == 2'h1) begin
      words = reloc_pkg::BOOT_WORDS_SIZE1;
    end else if (size_sel == 2'h2) begin
      words = reloc_pkg::BOOT_WORDS_SIZE2;
    end
    boot_start = 17'(reloc_pkg::FLASH_WORDS - words);
  endfunction

  // Vector slot address: base plus two words per vector number.
  function automatic logic [16:0] slot_addr(input logic [16:0] base, input logic [4:0] num);
    slot_addr = base + 17'(reloc_pkg::VECTOR_SLOT_WORDS * 17'(num));
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Relocation sequencer.

  reloc_ctrl_if ctl ();

  vector_unlock_seq u_seq (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ctl(ctl.seq)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Write channel.

  logic aw_full_r;
  logic [31:0] aw_addr_r;
  logic w_full_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  wire aw_take = s_axi_awvalid_i && s_axi_awready_o;
  wire w_take = s_axi_wvalid_i && s_axi_wready_o;
  wire wr_go = aw_full_r && w_full_r && !bvalid_r;
  wire wr_ctrl_hit = (aw_addr_r == reloc_pkg::CTRL_ADDR);
  wire wr_stat_hit = (aw_addr_r == reloc_pkg::STAT_ADDR);
  wire [1:0] wr_resp = (wr_ctrl_hit || wr_stat_hit) ? reloc_pkg::RESP_OKAY : reloc_pkg::RESP_SLVERR;

  assign s_axi_awready_o = !aw_full_r && !bvalid_r;
  assign s_axi_wready_o = !w_full_r && !bvalid_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;

  // Only the low byte holds the control bits; without it the write is dropped.
  assign ctl.wr_stb = wr_go && wr_ctrl_hit && w_strb_r[0];
  assign ctl.wr_unlock = w_data_r[reloc_pkg::UNLOCK_BIT];
  assign ctl.wr_select = w_data_r[reloc_pkg::SELECT_BIT];

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
    end else if (aw_take) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr_i;
    end else if (wr_go) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      w_full_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (w_take) begin
      w_full_r <= 1'b1;
      w_data_r <= s_axi_wdata_i;
      w_strb_r <= s_axi_wstrb_i;
    end else if (wr_go) begin
      w_full_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= reloc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_resp;
    end else if (s_axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lock gating and status.

  // Boot lock bits suppress interrupts by where code runs.
  wire lock_block = ctl.select ? (application_lock_bit_i && !exec_in_boot_i)
                               : (boot_section_lock_bit_i && exec_in_boot_i);

  wire [7:0] ctrl_view = {6'h00, ctl.select, ctl.unlock};
  wire [7:0] stat_view = {3'h0, boot_size_fuses_i, boot_reset_fuse_i, lock_block, ctl.mask};

  //////////////////////////////////////////////////////////////////////////////
  // Read channel.

  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  wire ar_take = s_axi_arvalid_i && s_axi_arready_o;
  wire rd_ctrl_hit = (s_axi_araddr_i == reloc_pkg::CTRL_ADDR);
  wire rd_stat_hit = (s_axi_araddr_i == reloc_pkg::STAT_ADDR);
  wire [31:0] rd_data = rd_ctrl_hit ? {24'h00_0000, ctrl_view}
                      : rd_stat_hit ? {24'h00_0000, stat_view} : 32'h0000_0000;
  wire [1:0] rd_resp = (rd_ctrl_hit || rd_stat_hit) ? reloc_pkg::RESP_OKAY : reloc_pkg::RESP_SLVERR;

  assign s_axi_arready_o = !rvalid_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= reloc_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_data;
      rresp_r <= rd_resp;
    end else if (s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Vector and reset addresses toward the core.

  wire [16:0] boot_base = boot_start(boot_size_fuses_i);
  wire [16:0] vec_base = ctl.select ? boot_base : reloc_pkg::APP_RESET_ADDR;
  // Reset fuse high means unprogrammed.
  wire [16:0] rst_addr = boot_reset_fuse_i ? reloc_pkg::APP_RESET_ADDR : boot_base;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vector_base_o <= reloc_pkg::APP_RESET_ADDR;
      vector_addr_o <= reloc_pkg::APP_RESET_ADDR;
      reset_addr_o <= reloc_pkg::APP_RESET_ADDR;
    end else begin
      vector_base_o <= vec_base;
      vector_addr_o <= slot_addr(vec_base, vector_num_i);
      reset_addr_o <= rst_addr;
    end
  end

  // The global enable is only read here; masking never writes it back.
  assign dispatch_mask_o = ctl.mask || lock_block;
  assign dispatch_enable_o = global_int_enable_i && !dispatch_mask_o;

endmodule

`default_nettype wire

// file: bench/core_model.sv
`timescale 1ns/10ps
`default_nettype none

module core_model (
  input wire logic sys_clk_i,
  input wire logic [4:0] want_vec_i,
  input wire logic want_boot_i,
  input wire logic want_gie_i,
  output logic [4:0] vector_num_o = 5'h0,
  output logic exec_in_boot_o = 1'b0,
  output logic global_int_enable_o = 1'b0
);
  // The core updates its fetch state only after an edge, like a pipeline stage.
  always @(posedge sys_clk_i) begin
    vector_num_o <= want_vec_i;
    exec_in_boot_o <= want_boot_i;
    global_int_enable_o <= want_gie_i;
  end
endmodule

`default_nettype wire

// file: bench/reloc_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module reloc_monitor (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic [1:0] boot_size_fuses_i,
  input wire logic boot_reset_fuse_i,
  input wire logic application_lock_bit_i,
  input wire logic boot_section_lock_bit_i,
  input wire logic exec_in_boot_i,
  input wire logic global_int_enable_i,
  input wire logic [4:0] vector_num_i,
  input wire logic [16:0] vector_addr_o,
  input wire logic [16:0] vector_base_o,
  input wire logic [16:0] reset_addr_o,
  input wire logic dispatch_mask_o,
  input wire logic dispatch_enable_o
);
  logic [1:0] live_r;

  // Past-value checks wait until the registers have seen real inputs.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) live_r <= 2'h0;
    else if (live_r != 2'h3) live_r <= live_r + 2'h1;
  end

  function automatic logic [16:0] boot_start(input logic [1:0] s);
    return 17'(18'h2_0000 - (18'h0_1000 >> s));
  endfunction

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  chk_enable_gate: assert property (dispatch_enable_o == (global_int_enable_i && !dispatch_mask_o))
    else $error("dispatch enable not gated by mask");
  chk_reset_target: assert property (live_r == 2'h3 |-> reset_addr_o ==
    ($past(boot_reset_fuse_i) ? 17'h0 : boot_start($past(boot_size_fuses_i)))) else $error("reset address wrong");
  chk_base_choice: assert property (live_r == 2'h3 |->
    vector_base_o == 17'h0 || vector_base_o == boot_start($past(boot_size_fuses_i))) else $error("vector base wrong");
  chk_vector_slot: assert property (live_r == 2'h3 && $stable(vector_base_o) |->
    vector_addr_o == 17'(vector_base_o + {$past(vector_num_i), 1'b0})) else $error("vector address wrong");
  chk_app_lock: assert property (vector_base_o != 17'h0 && application_lock_bit_i && !exec_in_boot_i
    |-> dispatch_mask_o) else $error("application lock not masking");
  chk_boot_lock: assert property (vector_base_o == 17'h0 && boot_section_lock_bit_i && exec_in_boot_i
    |-> dispatch_mask_o) else $error("boot lock not masking");
  chk_mask_span: assert property ($rose(dispatch_mask_o) && !application_lock_bit_i &&
    !boot_section_lock_bit_i |-> dispatch_mask_o[*4] ##[1:3] !dispatch_mask_o) else $error("mask span wrong");
  chk_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##2 s_axi_bvalid_o) else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read response late");
endmodule

bind vector_table_relocation reloc_monitor mon (.*);

`default_nettype wire

// file: bench/tb_vector_table_relocation.sv
`timescale 1ns/10ps
`default_nettype none

module tb_vector_table_relocation;
  localparam logic [31:0] ctrl_a = reloc_pkg::CTRL_ADDR;
  localparam logic [31:0] stat_a = reloc_pkg::STAT_ADDR;
  localparam logic [1:0] okay = reloc_pkg::RESP_OKAY;
  logic sys_clk_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i, s_axi_bready_i, s_axi_rready_i;
  logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i, s_axi_rdata_o;
  logic [2:0] s_axi_awprot_i, s_axi_arprot_i;
  logic [3:0] s_axi_wstrb_i;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, boot_size_fuses_i;
  logic boot_reset_fuse_i, application_lock_bit_i, boot_section_lock_bit_i, exec_in_boot_i, global_int_enable_i;
  logic [4:0] vector_num_i, want_vec;
  logic [16:0] vector_addr_o, vector_base_o, reset_addr_o;
  logic dispatch_mask_o, dispatch_enable_o, want_boot, want_gie;
  int error_cnt, checks_done, cyc, mask_cnt;

  vector_table_relocation uut (.*);
  core_model core (.sys_clk_i(sys_clk_i), .want_vec_i(want_vec), .want_boot_i(want_boot), .want_gie_i(want_gie),
    .vector_num_o(vector_num_i), .exec_in_boot_o(exec_in_boot_i), .global_int_enable_o(global_int_enable_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (dispatch_mask_o === 1'b1) mask_cnt <= mask_cnt + 1;
    if (cyc == 3000) begin
      error_cnt++;
      results();
    end
  end

  ////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, done;
    logic [1:0] r;
    done = 1'b0;
    s_axi_awvalid_i <= 1'b1;
    s_axi_awaddr_i <= a;
    s_axi_wvalid_i <= 1'b1;
    s_axi_wdata_i <= d;
    while (!done) begin
      @(negedge sys_clk_i);
      ah = s_axi_awready_o;
      wh = s_axi_wready_o;
      done = s_axi_bvalid_o;
      r = s_axi_bresp_o;
      @(posedge sys_clk_i);
      if (ah) s_axi_awvalid_i <= 1'b0;
      if (wh) s_axi_wvalid_i <= 1'b0;
    end
    cmp(32'(r), 32'(er));
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ah, done;
    logic [31:0] d;
    logic [1:0] r;
    done = 1'b0;
    s_axi_arvalid_i <= 1'b1;
    s_axi_araddr_i <= a;
    while (!done) begin
      @(negedge sys_clk_i);
      ah = s_axi_arready_o;
      done = s_axi_rvalid_o;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge sys_clk_i);
      if (ah) s_axi_arvalid_i <= 1'b0;
    end
    cmp(d, ed);
    cmp(32'(r), 32'(er));
  endtask

  ////////////////////////////////////////
  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i, application_lock_bit_i, boot_section_lock_bit_i} = 5'h0;
    {s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i, s_axi_awprot_i, s_axi_arprot_i} = 102'h0;
    {s_axi_bready_i, s_axi_rready_i, s_axi_wstrb_i, boot_size_fuses_i, boot_reset_fuse_i} = 9'h1_F1;
    {want_vec, want_boot, want_gie, cyc, mask_cnt, error_cnt, checks_done} = 0;
    want_gie = 1'b1;
    rst_i = 1'b1;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    settle(1);
    rd(ctrl_a, 32'h0, okay);
    rd(stat_a, 32'h4, okay);
    wr(stat_a, 32'hFF, okay);
    rd(stat_a, 32'h4, okay);
    wr(32'h100, 32'h0, reloc_pkg::RESP_SLVERR);
    rd(32'h100, 32'h0, reloc_pkg::RESP_SLVERR);
    for (int s = 0; s < 4; s++) begin
      for (int f = 0; f < 2; f++) begin
        boot_size_fuses_i <= 2'(s);
        boot_reset_fuse_i <= 1'(f);
        settle(2);
        cmp(32'(reset_addr_o), f ? 32'h0 : 32'h2_0000 - (32'h1000 >> s));
      end
    end
    boot_size_fuses_i <= 2'h0;
    wr(ctrl_a, 32'h2, okay);
    rd(ctrl_a, 32'h0, okay);
    s_axi_wstrb_i <= 4'hE;
    wr(ctrl_a, 32'h1, okay);
    s_axi_wstrb_i <= 4'hF;
    rd(ctrl_a, 32'h0, okay);
    settle(1);
    mask_cnt = 0;
    wr(ctrl_a, 32'h1, okay);
    #1;
    cmp(32'(dispatch_enable_o), 32'h0);
    rd(ctrl_a, 32'h1, okay);
    settle(6);
    cmp(mask_cnt, 4);
    cmp(32'(dispatch_enable_o), 32'h1);
    wr(ctrl_a, 32'h2, okay);
    rd(ctrl_a, 32'h0, okay);
    settle(1);
    mask_cnt = 0;
    wr(ctrl_a, 32'h1, okay);
    wr(ctrl_a, 32'h2, okay);
    settle(8);
    cmp(32'(mask_cnt > 4), 32'h1);
    rd(ctrl_a, 32'h2, okay);
    for (int n = 0; n < 32; n += 9) begin
      want_vec <= 5'(n);
      settle(3);
      cmp(32'(vector_addr_o), 32'h1_F000 + 2 * n);
      cmp(32'(vector_base_o), 32'h1_F000);
    end
    want_vec <= 5'h1;
    settle(3);
    cmp(32'(vector_addr_o), 32'h1_F002);
    application_lock_bit_i <= 1'b1;
    settle(3);
    cmp(32'(dispatch_enable_o), 32'h0);
    want_boot <= 1'b1;
    settle(3);
    cmp(32'(dispatch_enable_o), 32'h1);
    application_lock_bit_i <= 1'b0;
    boot_section_lock_bit_i <= 1'b1;
    settle(3);
    cmp(32'(dispatch_enable_o), 32'h1);
    rst_i <= 1'b1;
    settle(2);
    rst_i <= 1'b0;
    settle(1);
    rd(ctrl_a, 32'h0, okay);
    cmp(32'(vector_base_o), 32'h0);
    cmp(32'(dispatch_enable_o), 32'h0);
    wr(ctrl_a, 32'h1, okay);
    wr(ctrl_a, 32'h0, okay);
    settle(8);
    cmp(32'(vector_addr_o), 32'h2);
    cmp(32'(vector_base_o), 32'h0);
    cmp(32'(dispatch_enable_o), 32'h0);
    want_boot <= 1'b0;
    settle(3);
    cmp(32'(dispatch_enable_o), 32'h1);
    results();
  end
endmodule

`default_nettype wire
